// *** logic/rpc_top.sv ***
// receive payload control for one E1 link: per-timeslot substitution, inversion, gapping,
// pattern-test routing and signaling trunk code, with AXI4-Lite access to its registers.
// assumes octets arrive from the framer on aclk, tagged with their timeslot, in order.
//
// Notes on behaviour
// - 32 timeslot control registers, indices 00h-1fh
// - 32 data trunk code registers, indices 20h-3fh
// - signaling code registers 41h-4fh, 51h-5fh only
// - per-timeslot selector only when global is zero
// - code 001 substitutes the data trunk code
// - 010 A-law, 011 mu-law milliwatt pattern
// - inversion codes 000 to 011 decoded
// - inversion codes 100 to 111 decoded
// - gapping only in clock master with enable
// - gap whole timeslot, or lsb only
// - trunk code used by global or local select
// - test enable only in 8-bit/7-bit modes
// - direction 0 to detector, 1 from generator
// - 7-bit mode touches only seven msbs
// - tested timeslots form one continuous stream
// - signaling enable replaces signaling with code
// - global or local enable applies signaling code
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module rpc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [rpc_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [rpc_pkg::AXI_DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [rpc_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [rpc_pkg::AXI_DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [rpc_pkg::OCTET_W-1:0] in_data,
	input wire logic [rpc_pkg::SIG_W-1:0] in_sig,
	input wire logic [rpc_pkg::TS_W-1:0] in_ts,
	output logic out_valid,
	input wire logic out_ready,
	output logic [rpc_pkg::OCTET_W-1:0] out_data,
	output logic [rpc_pkg::SIG_W-1:0] out_sig,
	output logic [rpc_pkg::TS_W-1:0] out_ts,
	output logic [rpc_pkg::OCTET_W-1:0] out_gap,
	output logic det_valid,
	output logic [rpc_pkg::OCTET_W-1:0] det_data,
	output logic det_seven,
	input wire logic [rpc_pkg::OCTET_W-1:0] gen_data,
	output logic gen_take,
	output logic gen_seven
);
	import rpc_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic sig_mapped(input logic [TS_W-1:0] ts);
		sig_mapped = (ts != TS_NO_SIG_A) && (ts != TS_NO_SIG_B);
	endfunction : sig_mapped

	function automatic rpc_reg_kind_type reg_kind(input logic [IDX_W-1:0] idx);
		if (idx < IDX_TIMESLOT_DATA_TRUNK_CODE) begin
			reg_kind = RPC_RK_CTRL;
		end else if (idx < IDX_SIG) begin
			reg_kind = RPC_RK_TIMESLOT_DATA_TRUNK_CODE;
		end else if (idx >= IDX_SIG_FIRST && idx <= IDX_SIG_LAST && sig_mapped(idx[TS_W-1:0])) begin
			reg_kind = RPC_RK_SIG;
		end else if (idx == IDX_GLOBAL) begin
			reg_kind = RPC_RK_GLB;
		end else if (idx == IDX_STATUS) begin
			reg_kind = RPC_RK_STAT;
		end else begin
			reg_kind = RPC_RK_NONE;
		end
	endfunction : reg_kind

	function automatic logic [7:0] inv_mask(input logic s, input logic o, input logic e);
		// bit 1 of the timeslot is data[7]; odd positions below the msb are o, even are e
		inv_mask = {s, e, o, e, o, e, o, e};
	endfunction : inv_mask

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] ctrl_q [NUM_TS];
	logic [7:0] timeslot_data_trunk_code_q [NUM_TS];
	logic [7:0] sig_q [NUM_TS];
	logic [GLB_W-1:0] glb_q;
	logic [2:0] phase_q;
	logic [TS_W-1:0] last_ts_q;

	logic [IDX_W-1:0] aw_idx_q;
	logic [7:0] wbyte_q;
	logic wlane_q;
	logic wdir_q;
	logic skid_valid_q;
	logic aw_got_q, w_got_q;
	logic aw_got_d, w_got_d, bvalid_d;
	logic wr_fire;
	rpc_reg_kind_type wr_kind, rd_kind;
	logic [IDX_W-1:0] ar_idx;
	logic [AXI_DATA_W-1:0] rd_val;

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	assign wr_fire = aw_got_q && w_got_q && !bvalid;
	assign wr_kind = reg_kind(aw_idx_q);

	always_comb begin
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		bvalid_d = bvalid;
		if (awvalid && awready) begin
			aw_got_d = 1'b1;
		end
		if (wvalid && wready) begin
			w_got_d = 1'b1;
		end
		if (wr_fire) begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
		end else if (bvalid && bready) begin
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			awready <= 1'b0;
			wready <= 1'b0;
			aw_idx_q <= '0;
			wbyte_q <= REG_RESET;
			wlane_q <= 1'b0;
			wdir_q <= 1'b0;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			bvalid <= bvalid_d;
			awready <= !aw_got_d && !bvalid_d;
			wready <= !w_got_d && !bvalid_d;
			if (awvalid && awready) begin
				aw_idx_q <= awaddr[IDX_LSB +: IDX_W];
			end
			if (wvalid && wready) begin
				wbyte_q <= wdata[7:0];
				wlane_q <= wstrb[0];
				wdir_q <= wdata[GLB_DIR];
			end
			if (wr_fire) begin
				bresp <= (wr_kind == RPC_RK_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_TS; i++) begin
				ctrl_q[i] <= REG_RESET;
				timeslot_data_trunk_code_q[i] <= REG_RESET;
				sig_q[i] <= REG_RESET;
			end
			glb_q <= GLB_RESET;
		end else if (wr_fire && wlane_q) begin
			case (wr_kind)
				RPC_RK_CTRL: ctrl_q[aw_idx_q[TS_W-1:0]] <= wbyte_q;
				RPC_RK_TIMESLOT_DATA_TRUNK_CODE: timeslot_data_trunk_code_q[aw_idx_q[TS_W-1:0]] <= wbyte_q;
				RPC_RK_SIG: sig_q[aw_idx_q[TS_W-1:0]] <= wbyte_q & SIG_RW_MASK;
				RPC_RK_GLB: glb_q <= {wdir_q, wbyte_q};
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	assign ar_idx = araddr[IDX_LSB +: IDX_W];
	assign rd_kind = reg_kind(ar_idx);

	always_comb begin
		rd_val = '0;
		case (rd_kind)
			RPC_RK_CTRL: rd_val[7:0] = ctrl_q[ar_idx[TS_W-1:0]];
			RPC_RK_TIMESLOT_DATA_TRUNK_CODE: rd_val[7:0] = timeslot_data_trunk_code_q[ar_idx[TS_W-1:0]];
			RPC_RK_SIG: rd_val[7:0] = sig_q[ar_idx[TS_W-1:0]];
			RPC_RK_GLB: rd_val[GLB_W-1:0] = glb_q;
			RPC_RK_STAT: rd_val[15:0] = {3'h0, last_ts_q, 3'h0, skid_valid_q, out_valid, phase_q};
			default: rd_val = '0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
			arready <= 1'b0;
		end else begin
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= rd_val;
				rresp <= (rd_kind == RPC_RK_NONE) ? RESP_SLVERR : RESP_OKAY;
				arready <= 1'b0;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end else begin
				arready <= !rvalid;
			end
		end
	end

	// ----------------------------------------
	// payload path
	// ----------------------------------------
	logic [7:0] ctl;
	logic [7:0] sgr;
	logic [2:0] gsub, sub_sel;
	logic [1:0] mode;
	logic test_on, seven, gen_rep, det_rep, push;
	logic [7:0] sub_data, rep_data, fin_data, gap_mask;
	logic [3:0] fin_sig;

	assign ctl = ctrl_q[in_ts];
	assign sgr = sig_q[in_ts];
	assign gsub = glb_q[GLB_GSUB_LSB +: 3];
	assign mode = glb_q[GLB_MODE_LSB +: 2];
	assign push = in_valid && in_ready;
	assign sub_sel = (gsub != SUB_NONE) ? gsub : ctl[CTL_SUBST_LSB +: 3];
	assign test_on = sgr[SIG_TEST] && (mode == MODE_8BIT || mode == MODE_7BIT);
	assign seven = (mode == MODE_7BIT);
	assign gen_rep = test_on && glb_q[GLB_DIR];
	assign det_rep = test_on && !glb_q[GLB_DIR];

	always_comb begin
		case (sub_sel)
			SUB_TRUNK: sub_data = timeslot_data_trunk_code_q[in_ts];
			SUB_ALAW: sub_data = ALAW_MW[{3'h7 - phase_q, 3'h0} +: 8];
			SUB_MULAW: sub_data = MULAW_MW[{3'h7 - phase_q, 3'h0} +: 8];
			default: sub_data = in_data;
		endcase
	end

	// the lsb keeps the substituted value in 7-bit mode, so the generator only owns seven bits
	assign rep_data = !gen_rep ? sub_data : seven ? {gen_data[7:1], sub_data[0]} : gen_data;
	assign fin_data = rep_data ^ inv_mask(ctl[CTL_SIGN_BIT_INVERT], ctl[CTL_ODD_BITS_INVERT], ctl[CTL_EVEN_BITS_INVERT]);

	always_comb begin
		gap_mask = GAP_NONE;
		if (glb_q[GLB_MASTER] && glb_q[GLB_GAPPED_CLOCK_ENABLE]) begin
			if (ctl[CTL_GAP]) begin
				gap_mask = GAP_ALL;
			end else if (ctl[CTL_LSB_CLOCK_GAP]) begin
				gap_mask = GAP_LSB;
			end
		end
	end

	// timeslots 0 and 16 carry no signaling code, so they always pass through
	assign fin_sig = (sig_mapped(in_ts) && (glb_q[GLB_GSTRK] || sgr[SIG_SIGNALING_TRUNK_ENABLE])) ? sgr[3:0] : in_sig;

	// milliwatt phase steps once per frame, on the last timeslot
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_q <= 3'h0;
			last_ts_q <= '0;
		end else if (push) begin
			last_ts_q <= in_ts;
			if (in_ts == TS_LAST) begin
				phase_q <= phase_q + 3'h1;
			end
		end
	end

	// pattern unit taps: each tested octet is one more piece of a single stream
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			det_valid <= 1'b0;
			det_data <= REG_RESET;
			det_seven <= 1'b0;
			gen_take <= 1'b0;
			gen_seven <= 1'b0;
		end else begin
			det_valid <= push && det_rep;
			gen_take <= push && gen_rep;
			if (push && det_rep) begin
				det_data <= in_data;
				det_seven <= seven;
			end
			if (push && gen_rep) begin
				gen_seven <= seven;
			end
		end
	end

	// ----------------------------------------
	// two-entry output buffer
	// ----------------------------------------
	localparam int PAY_W = OCTET_W + SIG_W + TS_W + OCTET_W;
	logic [PAY_W-1:0] in_pay, skid_q;
	logic skid_valid_d, pop;

	assign in_pay = {fin_data, fin_sig, in_ts, gap_mask};
	assign pop = out_valid && out_ready;

	always_comb begin
		skid_valid_d = skid_valid_q;
		if (push && out_valid && !pop) begin
			skid_valid_d = 1'b1;
		end else if (pop) begin
			skid_valid_d = 1'b0;
		end
	end

	// ready is registered, so it only looks at the skid slot, which is free whenever it is high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			skid_valid_q <= 1'b0;
			skid_q <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
			{out_data, out_sig, out_ts, out_gap} <= '0;
		end else begin
			skid_valid_q <= skid_valid_d;
			in_ready <= !skid_valid_d;
			if (push && out_valid && !pop) begin
				skid_q <= in_pay;
			end
			if (pop && skid_valid_q) begin
				{out_data, out_sig, out_ts, out_gap} <= skid_q;
			end else if (push && (!out_valid || pop)) begin
				out_valid <= 1'b1;
				{out_data, out_sig, out_ts, out_gap} <= in_pay;
			end else if (pop) begin
				out_valid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic load_out;
	assign load_out = push && (!out_valid || pop) && !(pop && skid_valid_q);

	sequence s_write_done;
		wr_fire ##1 bvalid;
	endsequence

	property p_ctrl_written;
		wr_fire && wlane_q && wr_kind == RPC_RK_CTRL |=> ctrl_q[$past(aw_idx_q[TS_W-1:0])] == $past(wbyte_q);
	endproperty
	a_ctrl_written: assert property (p_ctrl_written) else $error("control write lost");

	property p_unmapped_err;
		wr_fire && wr_kind == RPC_RK_NONE |-> s_write_done ##0 bresp == RESP_SLVERR;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("no error on unmapped write");

	property p_sig_holes;
		sig_q[TS_NO_SIG_A] == REG_RESET && sig_q[TS_NO_SIG_B] == REG_RESET;
	endproperty
	a_sig_holes: assert property (p_sig_holes) else $error("code stored for timeslot 0 or 16");

	property p_trunk_out;
		load_out && sub_sel == SUB_TRUNK && !gen_rep && ctl[CTL_SIGN_BIT_INVERT +: 3] == 3'h0
			|=> out_data == $past(timeslot_data_trunk_code_q[in_ts]);
	endproperty
	a_trunk_out: assert property (p_trunk_out) else $error("trunk code not substituted");

	property p_global_wins;
		gsub != SUB_NONE |-> sub_sel == gsub;
	endproperty
	a_global_wins: assert property (p_global_wins) else $error("local selector overrides global");

	property p_pass;
		load_out && sub_sel == SUB_NONE && !gen_rep && ctl[CTL_SIGN_BIT_INVERT +: 3] == 3'h7 |=> out_data == ~$past(in_data);
	endproperty
	a_pass: assert property (p_pass) else $error("full inversion wrong");

	property p_gap_off;
		!(glb_q[GLB_MASTER] && glb_q[GLB_GAPPED_CLOCK_ENABLE]) && load_out |=> out_gap == GAP_NONE;
	endproperty
	a_gap_off: assert property (p_gap_off) else $error("gapping while disabled");

	property p_det_pulse;
		push && det_rep |=> det_valid && det_data == $past(in_data) ##1 !det_valid || $past(push && det_rep);
	endproperty
	a_det_pulse: assert property (p_det_pulse) else $error("detector tap wrong");

	property p_no_test_off;
		mode != MODE_8BIT && mode != MODE_7BIT |-> !gen_rep && !det_rep;
	endproperty
	a_no_test_off: assert property (p_no_test_off) else $error("pattern test outside its modes");

	property p_sig_code;
		load_out && sig_mapped(in_ts) && sgr[SIG_SIGNALING_TRUNK_ENABLE] |=> out_sig == $past(sgr[3:0]);
	endproperty
	a_sig_code: assert property (p_sig_code) else $error("signaling code not applied");

	property p_no_loss;
		out_valid && !out_ready && skid_valid_q |=> $stable(out_data) && skid_valid_q && !in_ready;
	endproperty
	a_no_loss: assert property (p_no_loss) else $error("buffer dropped a word under stall");

endmodule : rpc_top

// *** logic/rpc_pkg.sv ***
// receive payload control: register indices, field layout, codes and patterns.
// assumes a single 10 MHz clock domain shared with the framer and backplane logic.
package rpc_pkg;
	// ----------------------------------------
	// bus and geometry
	// ----------------------------------------
	localparam int AXI_ADDR_W = 9;
	localparam int AXI_DATA_W = 32;
	localparam int IDX_W = 7;
	localparam int TS_W = 5;
	localparam int NUM_TS = 32;
	localparam int OCTET_W = 8;
	localparam int SIG_W = 4;
	localparam int IDX_LSB = 2;
	// ----------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------
	localparam logic [IDX_W-1:0] IDX_TS_CTRL = 7'h00;
	localparam logic [IDX_W-1:0] IDX_TIMESLOT_DATA_TRUNK_CODE = 7'h20;
	localparam logic [IDX_W-1:0] IDX_SIG = 7'h40;
	localparam logic [IDX_W-1:0] IDX_SIG_FIRST = 7'h41;
	localparam logic [IDX_W-1:0] IDX_SIG_LAST = 7'h5f;
	localparam logic [IDX_W-1:0] IDX_GLOBAL = 7'h60;
	localparam logic [IDX_W-1:0] IDX_STATUS = 7'h61;
	localparam logic [TS_W-1:0] TS_NO_SIG_A = 5'h00;
	localparam logic [TS_W-1:0] TS_NO_SIG_B = 5'h10;
	localparam logic [TS_W-1:0] TS_LAST = 5'h1f;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTL_SUBST_LSB = 5;
	localparam int CTL_SIGN_BIT_INVERT = 4;
	localparam int CTL_ODD_BITS_INVERT = 3;
	localparam int CTL_EVEN_BITS_INVERT = 2;
	localparam int CTL_LSB_CLOCK_GAP = 1;
	localparam int CTL_GAP = 0;
	localparam int SIG_TEST = 6;
	localparam int SIG_SIGNALING_TRUNK_ENABLE = 4;
	localparam logic [7:0] SIG_RW_MASK = 8'h5f;
	localparam int GLB_GSUB_LSB = 0;
	localparam int GLB_GSTRK = 3;
	localparam int GLB_GAPPED_CLOCK_ENABLE = 4;
	localparam int GLB_MASTER = 5;
	localparam int GLB_MODE_LSB = 6;
	localparam int GLB_DIR = 8;
	localparam int GLB_W = 9;
	localparam logic [GLB_W-1:0] GLB_RESET = 9'h000;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ----------------------------------------
	// codes
	// ----------------------------------------
	localparam logic [2:0] SUB_NONE = 3'h0;
	localparam logic [2:0] SUB_TRUNK = 3'h1;
	localparam logic [2:0] SUB_ALAW = 3'h2;
	localparam logic [2:0] SUB_MULAW = 3'h3;
	localparam logic [1:0] MODE_8BIT = 2'h1;
	localparam logic [1:0] MODE_7BIT = 2'h2;
	localparam logic [7:0] GAP_NONE = 8'h00;
	localparam logic [7:0] GAP_LSB = 8'h01;
	localparam logic [7:0] GAP_ALL = 8'hff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// digital milliwatt sequences, one octet per frame, entry 0 first
	localparam logic [63:0] ALAW_MW = 64'h3421_2134_b4a1_a1b4;
	localparam logic [63:0] MULAW_MW = 64'h1e0b_0b1e_9e8b_8b9e;
	typedef enum logic [2:0] {
		RPC_RK_CTRL = 3'h1,
		RPC_RK_TIMESLOT_DATA_TRUNK_CODE = 3'h2,
		RPC_RK_SIG = 3'h3,
		RPC_RK_GLB = 3'h4,
		RPC_RK_STAT = 3'h5,
		RPC_RK_NONE = 3'h0
	} rpc_reg_kind_type;
endpackage : rpc_pkg

// *** tb/rpc_partner.sv ***
// backplane-side model: withholds ready at random or on command, and sources a
// generator pattern. assumes the bench feeds a free-running random word on aclk.
`timescale 1ns/1ns
module rpc_partner (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic hold,
	input wire logic stall_en,
	input wire logic [15:0] rnd,
	output logic out_ready,
	output logic [rpc_pkg::OCTET_W-1:0] gen_data
);
	import rpc_pkg::*;
	// ----------------------------------------
	// sink
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_ready <= 1'b0;
		end else begin
			out_ready <= !hold && !(stall_en && rnd[3:0] < 4'h6);
		end
	end
	// ----------------------------------------
	// pattern source
	// ----------------------------------------
	// changes every cycle so a sample taken at the wrong edge shows
	always_ff @(posedge aclk) begin
		gen_data <= rnd[15:8];
	end
endmodule : rpc_partner

// *** tb/rpc_top_tb_top.sv ***
// self-checking bench: register access over AXI4-Lite, payload stream against a model.
// assumes rpc_top and rpc_partner are compiled alongside.
`timescale 1ns/1ns
module rpc_top_tb_top;
	import rpc_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [AXI_DATA_W-1:0] wdata = '0;
	logic [3:0] wstrb = 4'h1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [AXI_DATA_W-1:0] rdata;
	logic in_valid = 1'b0, hold = 1'b0, stall_en = 1'b0, dir_b = 1'b0;
	logic [OCTET_W-1:0] in_data = '0;
	logic [SIG_W-1:0] in_sig = '0;
	logic [TS_W-1:0] in_ts = '0;
	logic in_ready, out_valid, out_ready, det_valid, det_seven, gen_take, gen_seven;
	logic [OCTET_W-1:0] out_data, out_gap, det_data, gen_data;
	logic [SIG_W-1:0] out_sig;
	logic [TS_W-1:0] out_ts;
	logic [31:0] lfsr_q = 32'he8df;
	logic [7:0] ctrl_m [NUM_TS] = '{default: 8'h00};
	logic [7:0] timeslot_data_trunk_code_m [NUM_TS] = '{default: 8'h00};
	logic [7:0] sig_m [NUM_TS] = '{default: 8'h00};
	logic [GLB_W-1:0] glb_m = GLB_RESET;
	logic [2:0] ph = 3'h0;
	logic [24:0] exp_q [$];
	logic [8:0] det_q [$];
	logic gen_q [$];
	int fail_count = 0;
	int cmp_count = 0;

	always #50 aclk = ~aclk;
	always @(posedge aclk) lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};

	rpc_top u_rpc_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_sig(in_sig), .in_ts(in_ts),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_sig(out_sig),
		.out_ts(out_ts), .out_gap(out_gap), .det_valid(det_valid), .det_data(det_data),
		.det_seven(det_seven), .gen_data(gen_data), .gen_take(gen_take), .gen_seven(gen_seven));
	rpc_partner u_rpc_partner (.aclk(aclk), .aresetn(aresetn), .hold(hold), .stall_en(stall_en),
		.rnd(lfsr_q[15:0]), .out_ready(out_ready), .gen_data(gen_data));

	// ----------------------------------------
	// reporting
	// ----------------------------------------
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic timeout();
		fail_count++;
		$display("[ERR] %0t wait limit reached", $time);
		end_sim();
	endtask : timeout

	function automatic logic sigok(input logic [4:0] t);
		return t != TS_NO_SIG_A && t != TS_NO_SIG_B;
	endfunction : sigok

	// ----------------------------------------
	// bus master
	// ----------------------------------------
	task automatic axi_wr(input logic [6:0] idx, input logic [7:0] d, input logic [1:0] er);
		int i;
		logic a;
		logic w;
		a = 1'b0;
		w = 1'b0;
		awaddr <= {idx, 2'b00};
		wdata <= {lfsr_q[22:0], dir_b, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (i = 0; i < 100 && !(a && w); i++) begin
			@(posedge aclk);
			if (!a && awready === 1'b1) begin
				a = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (bvalid === 1'b1) break;
		end
		if (i == 100 || !(a && w)) timeout();
		check(bresp, er);
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [6:0] idx, input logic [7:0] ed, input logic [1:0] er);
		int i;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (arready === 1'b1) break;
		end
		arvalid <= 1'b0;
		rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (rvalid === 1'b1) break;
		end
		if (i == 100) timeout();
		check(rdata, {23'h0, dir_b && idx == IDX_GLOBAL, ed});
		check(rresp, er);
		rready <= 1'b0;
	endtask : axi_rd

	task automatic cfg(input logic [6:0] idx, input logic [7:0] d);
		logic [7:0] v;
		v = (idx >= IDX_SIG && idx < IDX_GLOBAL) ? (d & SIG_RW_MASK) : d;
		axi_wr(idx, d, RESP_OKAY);
		axi_rd(idx, v, RESP_OKAY);
		if (idx < IDX_TIMESLOT_DATA_TRUNK_CODE) ctrl_m[idx[4:0]] = d;
		else if (idx < IDX_SIG) timeslot_data_trunk_code_m[idx[4:0]] = d;
		else if (idx < IDX_GLOBAL) sig_m[idx[4:0]] = v;
		else glb_m = {dir_b, d};
	endtask : cfg

	// ----------------------------------------
	// stream source and model
	// ----------------------------------------
	task automatic send(input logic [7:0] d, input logic [3:0] s, input logic [4:0] t);
		int i;
		logic [2:0] sub;
		logic [7:0] v;
		logic [7:0] m;
		logic [7:0] g;
		logic [3:0] so;
		logic [7:0] c;
		in_valid <= 1'b1;
		in_data <= d;
		in_sig <= s;
		in_ts <= t;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (in_ready === 1'b1) break;
		end
		if (i == 200) timeout();
		c = ctrl_m[t];
		sub = (glb_m[2:0] != SUB_NONE) ? glb_m[2:0] : c[7:5];
		case (sub)
			SUB_TRUNK: v = timeslot_data_trunk_code_m[t];
			SUB_ALAW: v = ALAW_MW[63 - 8 * ph -: 8];
			SUB_MULAW: v = MULAW_MW[63 - 8 * ph -: 8];
			default: v = d;
		endcase
		m = (c[4] ? 8'h80 : 8'h00) | (c[3] ? 8'h2a : 8'h00) | (c[2] ? 8'h55 : 8'h00);
		g = (glb_m[5] && glb_m[4]) ? (c[0] ? GAP_ALL : (c[1] ? GAP_LSB : GAP_NONE)) : GAP_NONE;
		so = (sigok(t) && (sig_m[t][4] || glb_m[3])) ? sig_m[t][3:0] : s;
		if (sigok(t) && sig_m[t][6] && (glb_m[7:6] == MODE_8BIT || glb_m[7:6] == MODE_7BIT)) begin
			if (glb_m[8]) begin
				// generator octet is the one standing at the push edge; 7-bit mode keeps the lsb
				v = (glb_m[7:6] == MODE_7BIT) ? {gen_data[7:1], v[0]} : gen_data;
				gen_q.push_back(glb_m[7:6] == MODE_7BIT);
			end else begin
				det_q.push_back({d, glb_m[7:6] == MODE_7BIT});
			end
		end
		exp_q.push_back({v ^ m, so, t, g});
		if (t == TS_LAST) ph = ph + 3'h1;
	endtask : send

	always @(posedge aclk) begin : mon
		logic [24:0] e;
		logic [8:0] q;
		if (aresetn === 1'b1) begin
			if (gen_take === 1'b1) check(gen_seven, (gen_q.size() > 0) ? gen_q.pop_front() : 1'bx);
			else check(gen_take, 1'b0);
			if (out_valid === 1'b1 && out_ready === 1'b1) begin
				e = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h1ffffff;
				check(out_data, e[24:17]);
				check(out_sig, e[16:13]);
				check(out_ts, e[12:8]);
				check(out_gap, e[7:0]);
			end
			if (det_valid === 1'b1) begin
				q = (det_q.size() > 0) ? det_q.pop_front() : 9'h1ff;
				check(det_seven, q[0]);
				check(q[0] ? {det_data[7:1], 1'b0} : det_data, q[0] ? {q[8:2], 1'b0} : q[8:1]);
			end
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	logic [7:0] glb_tab [14] = '{8'h00, 8'h01, 8'h02, 8'h0b, 8'h05, 8'h10, 8'h20, 8'h30, 8'h40, 8'h80,
		8'hc0, 8'h38, 8'h40, 8'h80};
	logic [6:0] rst_tab [9] = '{7'h00, 7'h1f, 7'h20, 7'h3f, 7'h41, 7'h4f, 7'h51, 7'h5f, 7'h60};
	logic [6:0] bad_tab [4] = '{7'h40, 7'h50, 7'h62, 7'h7f};

	initial begin
		int r;
		int t;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		foreach (rst_tab[k]) axi_rd(rst_tab[k], REG_RESET, RESP_OKAY);
		// a write without its low lane is answered but keeps nothing
		wstrb <= 4'he;
		axi_wr(IDX_TIMESLOT_DATA_TRUNK_CODE, 8'hff, RESP_OKAY);
		wstrb <= 4'h1;
		axi_rd(IDX_TIMESLOT_DATA_TRUNK_CODE, 8'h00, RESP_OKAY);
		// unmapped places answer with an error and keep nothing
		foreach (bad_tab[k]) begin
			axi_wr(bad_tab[k], 8'hff, RESP_SLVERR);
			axi_rd(bad_tab[k], 8'h00, RESP_SLVERR);
		end
		axi_wr(IDX_STATUS, 8'hff, RESP_OKAY);
		for (r = 0; r < 14; r++) begin
			stall_en <= r[0];
			// last two rounds drive the generator direction
			dir_b = (r >= 12);
			for (t = 0; t < NUM_TS; t++) begin
				cfg(7'(t), {3'(t / 4 + r), 3'(t), lfsr_q[1:0]});
				cfg(7'(IDX_TIMESLOT_DATA_TRUNK_CODE + t), lfsr_q[7:0]);
				if (sigok(5'(t))) cfg(7'(IDX_SIG + t), lfsr_q[7:0]);
			end
			cfg(IDX_GLOBAL, glb_tab[r]);
			for (t = 0; t < NUM_TS; t++) send(lfsr_q[7:0], lfsr_q[11:8], 5'(t));
			in_valid <= 1'b0;
		end
		// two words must survive a full stall: output register plus skid slot
		repeat (20) @(posedge aclk);
		hold <= 1'b1;
		send(8'h5a, 4'h3, 5'd1);
		send(8'ha5, 4'hc, 5'd2);
		in_valid <= 1'b0;
		repeat (3) @(posedge aclk);
		check(in_ready, 1'b0);
		check(out_valid, 1'b1);
		hold <= 1'b0;
		repeat (20) @(posedge aclk);
		check(exp_q.size(), 0);
		check(det_q.size(), 0);
		check(gen_q.size(), 0);
		end_sim();
	end
endmodule : rpc_top_tb_top
